/* src/apmc_regs.svh */
// Register offsets, field positions, reset values and timing figures of the power mode controller.
// Assumes a 25 MHz core clock and byte-wide register access from the serial front end.
`ifndef APMC_REGS_SVH
`define APMC_REGS_SVH

// Register offsets
`define APMC_OFS_QUIET_LEVEL 8'h25
`define APMC_OFS_QUIET_DUR 8'h26
`define APMC_OFS_RATE_SEL 8'h2C
`define APMC_OFS_OP_CTL 8'h2D

// Field positions
`define APMC_RATE_CODE_MSB 3
`define APMC_RATE_LP_BIT 4
`define APMC_OP_RUN_BIT 3
`define APMC_OP_DOZE_BIT 4
`define APMC_OP_CHAIN_BIT 5

// Reset values
`define APMC_RST_QUIET_LEVEL 8'h00
`define APMC_RST_QUIET_DUR 8'h00
`define APMC_RST_RATE_SEL 8'h0A
`define APMC_RST_OP_CTL 8'h00

// Rate codes
`define APMC_TOP_CODE 4'hF
`define APMC_SLEEP_CODE 4'h6
`define APMC_LP_MIN_CODE 4'h7
`define APMC_LP_MAX_CODE 4'hC

// Timing
`define APMC_CLK_HZ 25000000
`define APMC_TOP_RATE_HZ 3200
`define APMC_QUIET_UNIT_MS 1000

`endif

/* src/apmc_pkg.sv */
// Types shared by the power mode controller and its sample rate generator.
// Assumes nothing beyond a SystemVerilog compiler.
package apmc_pkg;

    typedef logic [7:0] apmc_byte_t;    // One register byte
    typedef logic [3:0] apmc_rate_t;    // Output data rate code

    // Operating modes, one-hot
    typedef enum logic [2:0] {
        APMC_STANDBY = 3'b001,
        APMC_MEASURE = 3'b010,
        APMC_SLEEP = 3'b100
    } apmc_state_e;

    // Whole state of the controller
    typedef struct packed {
        apmc_state_e mode;          // Current operating mode
        apmc_byte_t quiet_level;    // Inactivity threshold
        apmc_byte_t quiet_dur;      // Inactivity time, seconds
        apmc_byte_t rate_sel;       // Rate code and reduced sampling enable
        apmc_byte_t op_ctl;         // Run, doze and chain bits
        apmc_byte_t rdata;          // Registered read data
        logic [31:0] sec_cnt;       // Cycles within the current quiet second
        apmc_byte_t quiet_secs;     // Whole quiet seconds seen
    } apmc_top_s;

    // Whole state of the rate generator
    typedef struct packed {
        logic [31:0] cnt;   // Cycles since last conversion
        logic phase;        // Odd/even conversion in normal mode
        logic conv;         // Conversion strobe
        logic samp;         // Output sample strobe
    } apmc_tick_s;

endpackage

/* src/apmc_tick_if.sv */
// Link between the mode controller and its sample rate generator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface apmc_tick_if;
    import apmc_pkg::*;

    logic run;              // Sensing enabled
    logic low_power;        // Reduced internal sampling
    apmc_rate_t rate_code;  // Output data rate code
    logic convert_tick;     // One-cycle conversion strobe
    logic sample_tick;      // One-cycle output sample strobe

    modport ctrl (output run, output low_power, output rate_code,
                  input convert_tick, input sample_tick);
    modport gen (input run, input low_power, input rate_code,
                 output convert_tick, output sample_tick);
endinterface

/* src/apmc_rate_tick.sv */
// Sample rate generator: conversion and output sample strobes from a rate code.
// Assumes the controller holds run low whenever no measurement may be taken.
`timescale 1ns/10ps
`include "apmc_regs.svh"
module apmc_rate_tick #(
    parameter int BASE_DIV = `APMC_CLK_HZ / `APMC_TOP_RATE_HZ  // Cycles per sample at code 1111
) (
    input wire logic ref_clk,       // Core clock
    input wire logic rst,           // Asynchronous reset, active high
    apmc_tick_if.gen tk             // Controls in, strobes out
);
    import apmc_pkg::*;

    apmc_tick_s s_q;        // Registered state
    apmc_tick_s s_d;        // Next state
    logic [31:0] full;      // Cycles per output sample
    logic [31:0] period;    // Cycles per conversion

    // Each code step down doubles the period; normal mode converts twice per sample
    always_comb
    begin
        full = 32'(BASE_DIV) << (`APMC_TOP_CODE - tk.rate_code);
        period = tk.low_power ? full : (full >> 1);
        s_d = s_q;
        s_d.conv = 1'b0;
        s_d.samp = 1'b0;
        if (!tk.run)
        begin
            // Nothing is sampled while stopped
            s_d.cnt = 32'h0;
            s_d.phase = 1'b0;
        end
        else if (s_q.cnt >= period - 32'h1)
        begin
            // A rate change to a shorter period ends the current wait at once
            s_d.cnt = 32'h0;
            s_d.conv = 1'b1;
            if (tk.low_power)
            begin
                s_d.samp = 1'b1;
            end
            else
            begin
                s_d.phase = ~s_q.phase;
                s_d.samp = s_q.phase;
            end
        end
        else
        begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tk.convert_tick = s_q.conv;
    assign tk.sample_tick = s_q.samp;
endmodule // apmc_rate_tick

/* src/accel_power_mode_control.sv */
// Power mode controller: standby, measurement and automatic sleep, plus rate selection.
// Assumes register accesses arrive from a serial front end on ref_clk, one byte per access,
// and that motion_level comes from sensing logic on the same clock.
`timescale 1ns/10ps
`include "apmc_regs.svh"
module accel_power_mode_control #(
    parameter int BASE_DIV = `APMC_CLK_HZ / `APMC_TOP_RATE_HZ,  // Cycles per 3200 Hz sample
    parameter int SECOND_CYCLES = (`APMC_CLK_HZ / 1000) * `APMC_QUIET_UNIT_MS // Cycles per second
) (
    input wire logic ref_clk,                   // Core clock, 25 MHz
    input wire logic rst,                       // Asynchronous reset, active high
    input wire apmc_pkg::apmc_byte_t reg_addr,  // Register offset
    input wire apmc_pkg::apmc_byte_t reg_wdata, // Write data
    input wire logic reg_we,                    // Write strobe, one cycle
    input wire logic reg_re,                    // Read strobe, one cycle
    output apmc_pkg::apmc_byte_t reg_rdata,     // Read data, valid the cycle after reg_re
    input wire apmc_pkg::apmc_byte_t motion_level, // Motion magnitude, read on sample_tick
    output logic sensing_on,                    // Sensing functions powered
    output logic sleep_active,                  // Automatic sleep in force
    output logic low_power_active,              // Reduced internal sampling in force
    output apmc_pkg::apmc_rate_t active_rate,   // Rate code in force
    output logic convert_tick,                  // Internal conversion strobe
    output logic sample_tick                    // Output data sample strobe
);
    import apmc_pkg::*;

    apmc_top_s s_q;         // Registered state
    apmc_top_s s_d;         // Next state
    apmc_tick_if tk ();     // Link to the rate generator
    logic run_bit;          // Run sampling bit
    logic doze_ok;          // Doze and chain both set
    logic moved;            // Motion above threshold on this sample
    logic quiet_done;       // Inactivity has lasted long enough
    logic lp_range;         // Rate code where reduced sampling pays off

    // Decoded control bits
    always_comb
    begin
        run_bit = s_q.op_ctl[`APMC_OP_RUN_BIT];
        // Chaining is required too, so sleep only follows the inactivity function
        doze_ok = s_q.op_ctl[`APMC_OP_DOZE_BIT] & s_q.op_ctl[`APMC_OP_CHAIN_BIT];
        moved = tk.sample_tick && (motion_level > s_q.quiet_level);
        quiet_done = (s_q.quiet_secs >= s_q.quiet_dur);
        lp_range = (s_q.rate_sel[`APMC_RATE_CODE_MSB:0] >= `APMC_LP_MIN_CODE) &&
                   (s_q.rate_sel[`APMC_RATE_CODE_MSB:0] <= `APMC_LP_MAX_CODE);
    end

    // Next state: register access, mode machine, inactivity timing
    always_comb
    begin
        s_d = s_q;

        // Writes are taken in every mode, standby included
        if (reg_we)
        begin
            if (reg_addr == `APMC_OFS_QUIET_LEVEL)
            begin
                s_d.quiet_level = reg_wdata;
            end
            else if (reg_addr == `APMC_OFS_QUIET_DUR)
            begin
                s_d.quiet_dur = reg_wdata;
            end
            else if (reg_addr == `APMC_OFS_RATE_SEL)
            begin
                s_d.rate_sel = reg_wdata;
            end
            else if (reg_addr == `APMC_OFS_OP_CTL)
            begin
                s_d.op_ctl = reg_wdata;
            end
        end

        // Reads are captured so the data leaves a flip-flop; unmapped reads give zero
        if (reg_re)
        begin
            if (reg_addr == `APMC_OFS_QUIET_LEVEL)
            begin
                s_d.rdata = s_q.quiet_level;
            end
            else if (reg_addr == `APMC_OFS_QUIET_DUR)
            begin
                s_d.rdata = s_q.quiet_dur;
            end
            else if (reg_addr == `APMC_OFS_RATE_SEL)
            begin
                s_d.rdata = s_q.rate_sel;
            end
            else if (reg_addr == `APMC_OFS_OP_CTL)
            begin
                s_d.rdata = s_q.op_ctl;
            end
            else
            begin
                s_d.rdata = 8'h00;
            end
        end

        // Quiet-time bookkeeping: standby or motion restarts it, otherwise whole seconds accumulate
        if (s_q.mode == APMC_STANDBY || moved)
        begin
            s_d.sec_cnt = 32'h0;
            s_d.quiet_secs = 8'h00;
        end
        else if (s_q.sec_cnt >= 32'(SECOND_CYCLES) - 32'h1)
        begin
            s_d.sec_cnt = 32'h0;
            // Saturate so a long quiet spell never wraps back to zero
            if (s_q.quiet_secs != 8'hFF)
            begin
                s_d.quiet_secs = s_q.quiet_secs + 8'h01;
            end
        end
        else
        begin
            s_d.sec_cnt = s_q.sec_cnt + 32'h1;
        end

        // Mode machine; no branch touches the configuration registers
        case (s_q.mode)
            APMC_STANDBY:
            begin
                if (run_bit)
                begin
                    s_d.mode = APMC_MEASURE;
                end
            end
            APMC_MEASURE:
            begin
                if (!run_bit)
                begin
                    s_d.mode = APMC_STANDBY;
                end
                else if (doze_ok && !moved && quiet_done)
                begin
                    s_d.mode = APMC_SLEEP;
                end
            end
            APMC_SLEEP:
            begin
                if (!run_bit)
                begin
                    s_d.mode = APMC_STANDBY;
                end
                else if (!doze_ok || moved)
                begin
                    // Motion or a cleared doze or chain bit wakes to full measurement
                    s_d.mode = APMC_MEASURE;
                end
            end
            default:
            begin
                s_d.mode = APMC_STANDBY;
            end
        endcase
    end

    // State register; reset lands in standby with sensing off
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q.mode <= APMC_STANDBY;
            s_q.quiet_level <= `APMC_RST_QUIET_LEVEL;
            s_q.quiet_dur <= `APMC_RST_QUIET_DUR;
            s_q.rate_sel <= `APMC_RST_RATE_SEL;
            s_q.op_ctl <= `APMC_RST_OP_CTL;
            s_q.rdata <= 8'h00;
            s_q.sec_cnt <= 32'h0;
            s_q.quiet_secs <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Rate generator controls; sleep forces a slow code and drops reduced sampling
    always_comb
    begin
        tk.run = (s_q.mode != APMC_STANDBY);
        if (s_q.mode == APMC_SLEEP)
        begin
            tk.rate_code = `APMC_SLEEP_CODE;
            tk.low_power = 1'b0;
        end
        else
        begin
            tk.rate_code = s_q.rate_sel[`APMC_RATE_CODE_MSB:0];
            // Outside 12.5-400 Hz reduced sampling would save nothing, so it is not applied
            tk.low_power = s_q.rate_sel[`APMC_RATE_LP_BIT] && lp_range;
        end
    end

    // Sample rate generator
    apmc_rate_tick #(
        .BASE_DIV(BASE_DIV)
    ) u_rate (
        .ref_clk(ref_clk),
        .rst(rst),
        .tk(tk.gen)
    );

    // Outputs
    assign reg_rdata = s_q.rdata;
    assign sensing_on = tk.run;
    assign sleep_active = (s_q.mode == APMC_SLEEP);
    assign low_power_active = tk.low_power;
    assign active_rate = tk.rate_code;
    assign convert_tick = tk.convert_tick;
    assign sample_tick = tk.sample_tick;
endmodule // accel_power_mode_control

/* dv/apmc_monitor.sv */
// Port checker for the power mode controller.
// Assumes it is bound onto accel_power_mode_control.
`timescale 1ns/10ps
module apmc_monitor #(
    parameter int BASE_DIV = 8, // Cycles per top-rate sample
    parameter int SECOND_CYCLES = 20 // Cycles per quiet second
) (
    input wire logic ref_clk, // Core clock
    input wire logic rst, // Reset, active high
    input wire apmc_pkg::apmc_byte_t reg_addr, // Offset
    input wire apmc_pkg::apmc_byte_t reg_wdata, // Write data
    input wire logic reg_we, // Write strobe
    input wire logic reg_re, // Read strobe
    input wire apmc_pkg::apmc_byte_t reg_rdata, // Read data
    input wire apmc_pkg::apmc_byte_t motion_level, // Motion
    input wire logic sensing_on, // Sensing powered
    input wire logic sleep_active, // Auto sleep
    input wire logic low_power_active, // Reduced sampling
    input wire apmc_pkg::apmc_rate_t active_rate, // Rate in force
    input wire logic convert_tick, // Conversion strobe
    input wire logic sample_tick // Sample strobe
);
    import apmc_pkg::*;
    // Offsets that hold a register
    wire logic mapped = reg_addr inside {8'h25, 8'h26, 8'h2C, 8'h2D};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Writes that set or clear the run bit
    sequence s_run_wr; reg_we && reg_addr == 8'h2D && reg_wdata[3]; endsequence
    sequence s_stop_wr; reg_we && reg_addr == 8'h2D && !reg_wdata[3]; endsequence
    AST_BOOT_STANDBY: assert property ($past(rst) |-> !sensing_on && !sleep_active)
        else $error("not in standby after reset");
    AST_RUN_ON: assert property (s_run_wr |-> ##2 sensing_on)
        else $error("run write did not start sensing");
    AST_RUN_OFF: assert property (s_stop_wr |-> ##2 !sensing_on && !sleep_active)
        else $error("stop write did not reach standby");
    AST_STANDBY_QUIET: assert property (!sensing_on && !$past(sensing_on) |->
        !convert_tick && !sample_tick) else $error("strobe while in standby");
    AST_SLEEP_RATE: assert property (sleep_active |-> active_rate == 4'h6 &&
        !low_power_active) else $error("wrong rate in sleep");
    AST_SLEEP_SENSE: assert property (sleep_active |-> sensing_on)
        else $error("sleep without sensing");
    AST_LP_CODES: assert property (low_power_active |-> active_rate inside {[4'h7:4'hC]})
        else $error("low power on an unsupported code");
    AST_SAMPLE_CONV: assert property (sample_tick |-> convert_tick)
        else $error("sample without conversion");
    AST_UNMAPPED_ZERO: assert property (reg_re && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!$past(reg_re) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    // Cycles since the last conversion, saturating so a long standby never wraps
    logic [31:0] conv_gap;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            conv_gap <= 32'hFFFF_FFFF;
        end
        else if (convert_tick)
        begin
            conv_gap <= 32'h0;
        end
        else if (conv_gap != 32'hFFFF_FFFF)
        begin
            conv_gap <= conv_gap + 32'h1;
        end
    end
    // No code, not even the top one, may convert faster than twice per top-rate sample
    AST_CONV_SPACING: assert property (convert_tick |-> conv_gap >= 32'(BASE_DIV / 2 - 1))
        else $error("conversions closer than the top rate allows");
endmodule // apmc_monitor

bind accel_power_mode_control apmc_monitor #(.BASE_DIV(BASE_DIV),
    .SECOND_CYCLES(SECOND_CYCLES)) u_mon (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .motion_level(motion_level), .sensing_on(sensing_on),
    .sleep_active(sleep_active), .low_power_active(low_power_active),
    .active_rate(active_rate), .convert_tick(convert_tick), .sample_tick(sample_tick));

/* dv/apmc_host_model.sv */
// Host model: single byte register reads and writes.
// Assumes strobes are taken on the rising edge of ref_clk.
`timescale 1ns/10ps
module apmc_host_model (
    input wire logic ref_clk, // Core clock
    output apmc_pkg::apmc_byte_t reg_addr, // Offset
    output apmc_pkg::apmc_byte_t reg_wdata, // Write data
    output logic reg_we, // Write strobe
    output logic reg_re, // Read strobe
    input wire apmc_pkg::apmc_byte_t reg_rdata // Read data
);
    import apmc_pkg::*;
    // Idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end
    // Released fields are inverted so the design cannot lean on stale values
    task automatic wr(input apmc_byte_t a, input apmc_byte_t d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge ref_clk);
        reg_we = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Read data is settled one cycle after the strobe edge
    task automatic rd(input apmc_byte_t a, output apmc_byte_t d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_re = 1'b1;
        @(negedge ref_clk);
        reg_re = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // apmc_host_model

/* dv/accel_power_mode_control_bench.sv */
// Bench for the power mode controller: registers, rates, low power, sleep.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`include "apmc_regs.svh"
module accel_power_mode_control_bench;
    import apmc_pkg::*;
    logic ref_clk, rst, reg_we, reg_re, sensing_on, sleep_active; // Clock, reset, flags
    logic low_power_active, convert_tick, sample_tick; // Mode outputs
    apmc_byte_t reg_addr, reg_wdata, reg_rdata, motion_level, rd, lvl; // Bus and motion
    apmc_rate_t active_rate, code; // Rate in force, rate under test
    int fail_count = 0;
    int check_count = 0;
    int n;
    logic [31:0] gap, convs; // Sample spacing and conversions within it
    apmc_byte_t ofs [4] = '{8'h25, 8'h26, 8'h2C, 8'h2D};
    apmc_byte_t rstv [4] = '{`APMC_RST_QUIET_LEVEL, `APMC_RST_QUIET_DUR,
        `APMC_RST_RATE_SEL, `APMC_RST_OP_CTL};
    apmc_byte_t val [4];
    apmc_rate_t cases [6] = '{4'hF, 4'hC, 4'hE, 4'h7, 4'hA, 4'hF}; // Even normal, odd low power

    // Small counts keep the run short
    accel_power_mode_control #(.BASE_DIV(8), .SECOND_CYCLES(20)) u_dut (.ref_clk(ref_clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .motion_level(motion_level),
        .sensing_on(sensing_on), .sleep_active(sleep_active),
        .low_power_active(low_power_active), .active_rate(active_rate),
        .convert_tick(convert_tick), .sample_tick(sample_tick));
    apmc_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Sample spacing halves with each code step up from the base divider
    function automatic logic [31:0] exp_gap(input apmc_rate_t c);
        return 32'd8 << (4'hF - c);
    endfunction
    // Low power applies only to its supported codes
    function automatic logic [31:0] exp_conv(input apmc_rate_t c, input logic lp);
        return (lp && c >= 4'h7 && c <= 4'hC) ? 32'd1 : 32'd2;
    endfunction

    // Measure the gap between two samples, skipping the partial first period
    task automatic measure;
        n = 0;
        while (sample_tick !== 1'b1 && n < 9000)
        begin
            @(negedge ref_clk);
            n++;
        end
        gap = 0;
        convs = 0;
        do
        begin
            @(negedge ref_clk);
            gap++;
            convs += 32'(convert_tick);
        end while (sample_tick !== 1'b1 && gap < 9000);
    endtask

    // Configure in standby, run, measure, stop
    task automatic rate_case(input apmc_rate_t c, input logic lp);
        u_host.wr(8'h2C, {3'h0, lp, c});
        u_host.wr(8'h2D, 8'h08);
        repeat (2) @(negedge ref_clk);
        chk(sensing_on, 1);
        measure();
        chk(gap, exp_gap(c));
        chk(convs, exp_conv(c, lp));
        chk(low_power_active, exp_conv(c, lp) == 1);
        chk(active_rate, c);
        u_host.wr(8'h2D, 8'h00);
        repeat (2) @(negedge ref_clk);
        chk(sensing_on, 0);
    endtask

    // Watchdog: the tests need well under 30000 cycles
    initial
    begin
        #(40 * 60000);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        rst = 1'b1;
        motion_level = 8'h00;
        void'($urandom(85772));
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        chk(sensing_on, 0);
        foreach (ofs[i])
        begin
            u_host.rd(ofs[i], rd);
            chk(rd, rstv[i]);
            val[i] = $urandom;
        end
        val[3][3] = 1'b0; // Stay in standby while configuring
        foreach (ofs[i]) u_host.wr(ofs[i], val[i]);
        foreach (ofs[i])
        begin
            u_host.rd(ofs[i], rd);
            chk(rd, val[i]);
        end
        u_host.wr(8'h2E, 8'h5A);
        u_host.rd(8'h2E, rd);
        chk(rd, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            code = (k < 6) ? cases[k] : (k[0] ? 4'h7 : 4'hA) + 4'($urandom % 6);
            rate_case(code, k[0]);
        end
        u_host.rd(8'h25, rd);
        chk(rd, val[0]);
        lvl = 8'h40 + 8'($urandom % 64);
        u_host.wr(8'h25, lvl);
        u_host.wr(8'h26, 8'h02);
        u_host.wr(8'h2C, 8'h0F);
        u_host.wr(8'h2D, 8'h38);
        n = 0;
        while (sleep_active !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            motion_level = 8'($urandom % lvl);
            n++;
        end
        chk(sleep_active, 1);
        chk(n >= 40, 1);
        chk(active_rate, 4'h6);
        motion_level = 8'hFF;
        n = 0;
        while (sleep_active !== 1'b0 && n < 9000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(sleep_active, 0);
        chk(sensing_on, 1);
        // Fall asleep again, then wake by clearing doze alone
        motion_level = 8'h00;
        repeat (60) @(negedge ref_clk);
        chk(sleep_active, 1);
        u_host.wr(8'h2D, 8'h28);
        repeat (2) @(negedge ref_clk);
        chk(sleep_active, 0);
        chk(sensing_on, 1);
        // Quiet time already served, so doze on sends it straight back to sleep
        u_host.wr(8'h2D, 8'h38);
        repeat (2) @(negedge ref_clk);
        chk(sleep_active, 1);
        // Stop straight out of sleep
        u_host.wr(8'h2D, 8'h00);
        repeat (50) @(negedge ref_clk);
        chk(sensing_on, 0);
        chk(sleep_active, 0);
        u_host.rd(8'h2C, rd);
        chk(rd, 8'h0F);
        u_host.rd(8'h25, rd);
        chk(rd, lvl);
        report_and_stop();
    end
endmodule // accel_power_mode_control_bench
